// File: src/la_acq.sv
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
module la_acq #(
	parameter int DISP_UNIT_CYC = la_pkg::DISP_UNIT_CYC,
	parameter int INTVL_MAX_CYC = la_pkg::MAX_INTVL_CYC,
	parameter int MEM_WORDS = la_pkg::MEM_WORDS
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// Register port
	input wire logic [5:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	output logic [31:0] o_rdata,
	// Probe pins
	input wire logic [15:0] i_probe,
	input wire logic i_ext_clk,
	input wire logic i_prb_qual,
	input wire logic i_ext_trig,
	// Status outputs
	output logic [1:0] o_fmt,
	output logic o_disp_store,
	output logic o_trig_int_n,
	output logic o_mreset,
	output logic [2:0] o_aux,
	output logic o_triggered,
	output logic o_too_fast,
	output logic o_wr_match,
	output logic o_store_clk
);
	localparam int DEPTH_MAX = MEM_WORDS * 4;
	localparam int AW = $clog2(DEPTH_MAX);
	localparam int WA = $clog2(MEM_WORDS);

	if (MEM_WORDS < 2 || AW > 10 || DISP_UNIT_CYC < 1 || INTVL_MAX_CYC < 1) begin : g_chk
		$error("la_acq: parameter out of range");
	end

	// ==========
	// Reset release
	logic [1:0] rs_q;
	logic rst_n;
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			rs_q <= 2'h0;
		end else begin
			rs_q <= {rs_q[0], 1'b1};
		end
	end
	assign rst_n = rs_q[1];

	// ==========
	// Registers
	la_pkg::la_ctrl_s ctrl_q, ctrl_d;
	logic [10:0] disp_q, disp_d;
	logic [4:0] filt_q, filt_d;
	logic [17:0] care_q, care_d, lvl_q, lvl_d;
	logic [8:0] route_q, route_d;
	logic [WA-1:0] midx_q, midx_d;
	logic [31:0] rdata_d;
	logic [15:0] mdat;
	la_pkg::la_stat_s stat;
	always_comb begin
		ctrl_d = ctrl_q;
		// Manual requests are one-cycle pulses
		ctrl_d.man_trig = 1'b0;
		ctrl_d.man_rst = 1'b0;
		disp_d = disp_q;
		filt_d = filt_q;
		care_d = care_q;
		lvl_d = lvl_q;
		route_d = route_q;
		midx_d = midx_q;
		rdata_d = 32'h0;
		if (i_we) begin
			unique case (i_addr)
				la_pkg::OFS_CTRL: ctrl_d = {12'h0, i_wdata[19:0]};
				la_pkg::OFS_DISP: disp_d = i_wdata[10:0];
				// Filter saturates at its longest hold-off
				la_pkg::OFS_FILT: filt_d = (i_wdata[4:0] > la_pkg::FILT_MAX_CYC) ?
					la_pkg::FILT_MAX_CYC : i_wdata[4:0]; // see RULE19
				la_pkg::OFS_CARE: care_d = i_wdata[17:0];
				la_pkg::OFS_LVL: lvl_d = i_wdata[17:0];
				la_pkg::OFS_ROUTE: route_d = i_wdata[8:0];
				la_pkg::OFS_MIDX: midx_d = i_wdata[WA-1:0];
				default: ;
			endcase
		end
		if (i_re) begin
			unique case (i_addr)
				la_pkg::OFS_CTRL: rdata_d = 32'(ctrl_q);
				la_pkg::OFS_DISP: rdata_d = {21'h0, disp_q};
				la_pkg::OFS_FILT: rdata_d = {27'h0, filt_q};
				la_pkg::OFS_CARE: rdata_d = {14'h0, care_q};
				la_pkg::OFS_LVL: rdata_d = {14'h0, lvl_q};
				la_pkg::OFS_ROUTE: rdata_d = {23'h0, route_q};
				la_pkg::OFS_STAT: rdata_d = 32'(stat);
				la_pkg::OFS_MIDX: rdata_d = 32'(midx_q);
				la_pkg::OFS_MDAT: rdata_d = {16'h0, mdat};
				default: rdata_d = 32'h0;
			endcase
		end
	end
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= '0;
			disp_q <= la_pkg::DISP_RST;
			filt_q <= 5'h0;
			care_q <= 18'h0;
			lvl_q <= 18'h0;
			route_q <= la_pkg::ROUTE_RST;
			midx_q <= '0;
			o_rdata <= 32'h0;
		end else begin
			ctrl_q <= ctrl_d;
			disp_q <= disp_d;
			filt_q <= filt_d;
			care_q <= care_d;
			lvl_q <= lvl_d;
			route_q <= route_d;
			midx_q <= midx_d;
			o_rdata <= rdata_d;
		end
	end

	// ==========
	// Pin sampling
	la_pkg::la_pins_s s1_q, s2_q, pv_q, pins;
	logic ch0_q, ch0_d;
	logic [19:0] div_q, div_d, cyc;
	logic ext_sel, clk_edge, tick, ch0_ev, xt_ev;
	assign pins = '{ext_trig: i_ext_trig, prb_qual: i_prb_qual, ext_clk: i_ext_clk,
		probe: i_probe};
	always_comb begin
		ext_sel = ctrl_q.intvl >= la_pkg::INTVL_STEPS; // see RULE6
		cyc = la_pkg::intvl_cyc(ctrl_q.intvl);
		// Slowest rate can be cut short for simulation
		if (cyc > 20'(INTVL_MAX_CYC)) begin
			cyc = 20'(INTVL_MAX_CYC);
		end
		clk_edge = ctrl_q.ext_clk_pol ? (pv_q.ext_clk & ~s2_q.ext_clk) :
			(~pv_q.ext_clk & s2_q.ext_clk); // see RULE5
		div_d = (ext_sel || div_q >= cyc - 20'h1) ? 20'h0 : div_q + 20'h1;
		tick = ext_sel ? clk_edge : (div_q >= cyc - 20'h1); // see RULE6
		ch0_d = tick ? s2_q.probe[0] : ch0_q;
		ch0_ev = tick & s2_q.probe[0] & ~ch0_q;
		xt_ev = ctrl_q.ext_trig_pol ? (pv_q.ext_trig & ~s2_q.ext_trig) :
			(~pv_q.ext_trig & s2_q.ext_trig); // see RULE15
	end
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			pv_q <= '0;
			div_q <= 20'h0;
			ch0_q <= 1'b0;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			pv_q <= s2_q;
			div_q <= div_d;
			ch0_q <= ch0_d;
		end
	end

	// ==========
	// Pattern matcher
	logic [17:0] vec, hit;
	logic raw, wrm_q, wrm_d, wr_ev;
	logic [4:0] fc_q, fc_d;
	for (genvar b = 0; b < la_pkg::N_PAT; b++) begin : g_pat
		// Clear care bit means don't care
		assign hit[b] = ~care_q[b] | ~(vec[b] ^ lvl_q[b]); // see RULE16 RULE17
	end
	always_comb begin
		vec = {s2_q.prb_qual, s2_q.ext_trig, s2_q.probe};
		raw = &hit;
		fc_d = raw ? ((fc_q < filt_q) ? fc_q + 5'h1 : fc_q) : 5'h0;
		if (ctrl_q.wr_async) begin
			// Match must persist for the filter time
			wrm_d = raw && (fc_q >= filt_q); // see RULE18 RULE19
		end else begin
			wrm_d = clk_edge ? raw : wrm_q; // see RULE18
		end
		wr_ev = wrm_d & ~wrm_q;
	end
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wrm_q <= 1'b0;
			fc_q <= 5'h0;
		end else begin
			wrm_q <= wrm_d;
			fc_q <= fc_d;
		end
	end

	// ==========
	// Acquisition sequencer
	la_pkg::la_state_e st_q, st_d;
	logic [AW-1:0] wptr_q, wptr_d, tptr_q, tptr_d, post_q, post_d, scan_q, scan_d, dm1;
	logic [AW-1:0] tgt;
	logic full_q, full_d, trgd_q, trgd_d, sclk_q, sclk_d;
	logic [9:0] dcnt_q, dcnt_d;
	logic [31:0] pre_q, pre_d;
	logic [4:0] bcnt_q, bcnt_d;
	logic blink_q, blink_d, unit, st_en, store, trig_ev, acc;
	logic [WA-1:0] wa;
	logic [15:0] wm, wd;
	logic [15:0] mem_q [MEM_WORDS];
	always_comb begin
		// Depth per format from one shared array
		if (ctrl_q.fmt == la_pkg::FMT_4) begin
			dm1 = AW'(DEPTH_MAX - 1); // see RULE10
			wa = WA'(wptr_q >> 2);
			wm = 16'h000f << {wptr_q[1:0], 2'h0};
			wd = {4{s2_q.probe[3:0]}};
		end else if (ctrl_q.fmt == la_pkg::FMT_8) begin
			dm1 = AW'(DEPTH_MAX / 2 - 1); // see RULE10
			wa = WA'(wptr_q >> 1);
			wm = 16'h00ff << {wptr_q[0], 3'h0};
			wd = {2{s2_q.probe[7:0]}};
		end else begin
			dm1 = AW'(MEM_WORDS - 1); // see RULE10
			wa = WA'(wptr_q);
			wm = 16'hffff;
			wd = s2_q.probe;
		end
		unique case (ctrl_q.dpos)
			la_pkg::POS_POST: tgt = dm1; // see RULE13
			la_pkg::POS_CENTER: tgt = AW'((dm1 + 1) >> 1);
			default: tgt = '0;
		endcase
		st_en = ~ctrl_q.qual_en | ((ctrl_q.qual_src ? s2_q.ext_trig : s2_q.prb_qual)
			== ctrl_q.qual_lvl); // see RULE11
		store = (st_q == la_pkg::ST_STORE) && tick && st_en; // see RULE11
		unique case (ctrl_q.trig_src)
			la_pkg::SRC_CH0: trig_ev = ch0_ev; // see RULE14
			la_pkg::SRC_EXT: trig_ev = xt_ev;
			la_pkg::SRC_WR: trig_ev = wr_ev;
			default: trig_ev = 1'b0;
		endcase
		trig_ev = trig_ev | ctrl_q.man_trig; // see RULE14
		acc = (st_q == la_pkg::ST_STORE) && !trgd_q && trig_ev &&
			(ctrl_q.first_trig || full_q); // see RULE1 RULE2
		unit = pre_q >= 32'(DISP_UNIT_CYC - 1);
		pre_d = unit ? 32'h0 : pre_q + 32'h1;
		bcnt_d = unit ? ((bcnt_q >= la_pkg::BLINK_UNITS - 5'h1) ? 5'h0 : bcnt_q + 5'h1) :
			bcnt_q;
		blink_d = blink_q ^ (unit && bcnt_q >= la_pkg::BLINK_UNITS - 5'h1);
		st_d = st_q;
		wptr_d = wptr_q;
		tptr_d = tptr_q;
		post_d = post_q;
		scan_d = scan_q;
		full_d = full_q;
		trgd_d = trgd_q;
		dcnt_d = dcnt_q;
		sclk_d = store;
		unique case (st_q)
			la_pkg::ST_RST: begin
				// Single cycle of clearing before storing
				wptr_d = '0;
				full_d = 1'b0;
				trgd_d = 1'b0; // see RULE12
				dcnt_d = 10'h0;
				st_d = la_pkg::ST_STORE; // see RULE23
			end
			la_pkg::ST_STORE: begin
				if (store) begin
					wptr_d = (wptr_q >= dm1) ? '0 : wptr_q + AW'(1);
					if (wptr_q >= dm1) begin
						full_d = 1'b1; // see RULE1
					end
					if (trgd_q) begin
						post_d = post_q - AW'(1);
						if (post_q <= AW'(1)) begin
							st_d = la_pkg::ST_DISP; // see RULE23
						end
					end
				end
				if (acc) begin
					trgd_d = 1'b1; // see RULE12
					post_d = tgt;
					// Pre-trigger marks the newest sample
					tptr_d = (tgt != '0) ? wptr_q : ((wptr_q == '0) ? dm1 : wptr_q - AW'(1));
					if (tgt == '0) begin
						st_d = la_pkg::ST_DISP; // see RULE13
					end
				end
				scan_d = wptr_d;
				if (ctrl_q.man_rst) begin
					st_d = la_pkg::ST_RST; // see RULE9
				end
			end
			la_pkg::ST_DISP: begin
				// Scan runs oldest to newest, one sample per cycle
				scan_d = (scan_q >= dm1) ? '0 : scan_q + AW'(1);
				if (unit) begin
					dcnt_d = dcnt_q + 10'h1;
				end
				if (ctrl_q.man_rst) begin
					st_d = la_pkg::ST_RST; // see RULE9
				end else if (!disp_q[la_pkg::INF_BIT] && dcnt_q >= disp_q[9:0]) begin
					st_d = la_pkg::ST_RST; // see RULE8
				end
			end
			default: st_d = la_pkg::ST_RST;
		endcase
	end
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= la_pkg::ST_RST;
			wptr_q <= '0;
			tptr_q <= '0;
			post_q <= '0;
			scan_q <= '0;
			full_q <= 1'b0;
			trgd_q <= 1'b0;
			dcnt_q <= 10'h0;
			pre_q <= 32'h0;
			bcnt_q <= 5'h0;
			blink_q <= 1'b0;
			sclk_q <= 1'b0;
		end else begin
			st_q <= st_d;
			wptr_q <= wptr_d;
			tptr_q <= tptr_d;
			post_q <= post_d;
			scan_q <= scan_d;
			full_q <= full_d;
			trgd_q <= trgd_d;
			dcnt_q <= dcnt_d;
			pre_q <= pre_d;
			bcnt_q <= bcnt_d;
			blink_q <= blink_d;
			sclk_q <= sclk_d;
		end
	end
	// Sample memory holds no reset; contents are undefined until stored
	always_ff @(posedge i_clk_sys) begin
		if (store) begin
			mem_q[wa] <= (mem_q[wa] & ~wm) | (wd & wm); // see RULE10
		end
	end
	assign mdat = (32'(midx_q) < MEM_WORDS) ? mem_q[midx_q] : 16'h0;

	// ==========
	// Status outputs
	logic [1:0] fmt_d;
	logic ds_d, ti_d, mr_d, tf, tf_d;
	logic [4:0] sts;
	logic [2:0] aux_d;
	always_comb begin
		fmt_d = {ctrl_q.fmt != la_pkg::FMT_8 && ctrl_q.fmt != la_pkg::FMT_4,
			ctrl_q.fmt == la_pkg::FMT_4};
		fmt_d = {~fmt_d[1], fmt_d[0]}; // see RULE3
		ds_d = (st_d == la_pkg::ST_STORE); // see RULE20
		ti_d = !(st_d == la_pkg::ST_DISP && scan_d == tptr_d); // see RULE21
		mr_d = (st_d == la_pkg::ST_RST); // see RULE22
		tf = !ext_sel && ((ctrl_q.intvl == 5'h0 && ctrl_q.fmt == la_pkg::FMT_8) ||
			(ctrl_q.intvl <= la_pkg::INTVL_20NS && ctrl_q.fmt != la_pkg::FMT_8 &&
			ctrl_q.fmt != la_pkg::FMT_4)); // see RULE7
		tf_d = tf & blink_d;
		sts = {mr_d, ti_d, ds_d, fmt_d[0], fmt_d[1]};
		for (int k = 0; k < la_pkg::N_AUX; k++) begin
			// Unused selector codes give a low pin
			aux_d[k] = (route_q[3*k +: 3] < 3'(la_pkg::N_STS)) ?
				sts[route_q[3*k +: 3]] : 1'b0; // see RULE4
		end
		stat = '{rsvd: 16'h0, wr_match: wrm_q, too_fast: tf, trgd: trgd_q,
			full: full_q, state: st_q, wptr: 10'(wptr_q)};
	end
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_fmt <= 2'h3;
			o_disp_store <= 1'b0;
			o_trig_int_n <= 1'b1;
			o_mreset <= 1'b1;
			o_aux <= 3'h0;
			o_triggered <= 1'b0;
			o_too_fast <= 1'b0;
			o_wr_match <= 1'b0;
			o_store_clk <= 1'b0;
		end else begin
			o_fmt <= fmt_d;
			o_disp_store <= ds_d;
			o_trig_int_n <= ti_d;
			o_mreset <= mr_d;
			o_aux <= aux_d;
			o_triggered <= trgd_d; // see RULE12
			o_too_fast <= tf_d;
			o_wr_match <= wrm_d;
			o_store_clk <= sclk_q;
		end
	end
endmodule

// File: common/la_pkg.sv
// What this block does
// RULE1: Full-display setting fills whole memory once before accepting a trigger.
// RULE2: First-trigger setting accepts the first trigger after reset, no fill wait.
// RULE3: Format outputs: HI,HI four channels; HI,LO eight; LO,LO sixteen.
// RULE4: Router sends any three of five status signals to three aux pins.
// RULE5: External clocking samples on the edge chosen by clock polarity.
// RULE6: Internal interval 10 ns to 5 ms in 5-2-1 steps; external setting.
// RULE7: Too-fast flashes: 10 ns at eight, 10/20 ns at sixteen; never external.
// RULE8: Display holds about 1 to 10 s, or forever, then new store.
// RULE9: Manual reset overrides display time and starts a new store cycle.
// RULE10: Memory holds 4x1016, 8x508 or 16x254 samples by format.
// RULE11: Qualifier gates the store clock; samples stored only when enabled.
// RULE12: Triggered flag sets on first accepted trigger, holds until reset.
// RULE13: Data position places samples after, around or before the trigger.
// RULE14: Trigger from channel 0 rise, external input or matcher; manual too.
// RULE15: External trigger taken on rising or falling edge by polarity.
// RULE16: Every data channel has high, low or don't-care match setting.
// RULE17: External and probe qualifiers each add a three-state match term.
// RULE18: Sync match rises on external clock edge; async rises at once.
// RULE19: Async only: filter holds off match for up to 300 ns.
// RULE20: Display-store output low in display, high in store.
// RULE21: Trigger-intensify output low during the displayed trigger sample.
// RULE22: Master reset output high in reset, low in store or display.
// RULE23: Cycle runs reset, store to trigger plus fill, display, reset.
package la_pkg;
	// ==========
	// Timing
	localparam int CLK_NS = 10;
	localparam int BASE_NS = 10;
	localparam int BASE_CYC = (BASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int MAX_INTVL_NS = 5_000_000;
	localparam int MAX_INTVL_CYC = MAX_INTVL_NS / CLK_NS;
	localparam logic [4:0] INTVL_STEPS = 5'h12;
	localparam logic [4:0] INTVL_20NS = 5'h01;
	localparam int DISP_UNIT_NS = 10_000_000;
	localparam int DISP_UNIT_CYC = DISP_UNIT_NS / CLK_NS;
	localparam int FILT_MAX_NS = 300;
	localparam logic [4:0] FILT_MAX_CYC = 5'(FILT_MAX_NS / CLK_NS);
	localparam logic [4:0] BLINK_UNITS = 5'h19;
	localparam int MEM_WORDS = 254;
	localparam int N_CH = 16;
	localparam int N_PAT = 18;
	localparam int N_AUX = 3;
	localparam int N_STS = 5;
	// ==========
	// Register map
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_DISP = 6'h04;
	localparam logic [5:0] OFS_FILT = 6'h08;
	localparam logic [5:0] OFS_CARE = 6'h0c;
	localparam logic [5:0] OFS_LVL = 6'h10;
	localparam logic [5:0] OFS_ROUTE = 6'h14;
	localparam logic [5:0] OFS_STAT = 6'h18;
	localparam logic [5:0] OFS_MIDX = 6'h1c;
	localparam logic [5:0] OFS_MDAT = 6'h20;
	localparam logic [10:0] DISP_RST = 11'h064;
	localparam logic [8:0] ROUTE_RST = 9'h088;
	localparam int INF_BIT = 10;
	// ==========
	// Types
	typedef enum logic [1:0] {FMT_4 = 2'h0, FMT_8 = 2'h1, FMT_16 = 2'h2} la_fmt_e;
	typedef enum logic [1:0] {POS_POST = 2'h0, POS_CENTER = 2'h1, POS_PRE = 2'h2} la_pos_e;
	typedef enum logic [1:0] {SRC_CH0 = 2'h0, SRC_EXT = 2'h1, SRC_WR = 2'h2} la_src_e;
	typedef enum logic [1:0] {ST_RST = 2'h0, ST_STORE = 2'h1, ST_DISP = 2'h3} la_state_e;
	typedef struct packed {
		logic [11:0] rsvd;
		logic qual_lvl;
		logic qual_src;
		logic qual_en;
		logic man_rst;
		logic man_trig;
		logic wr_async;
		logic ext_trig_pol;
		logic [1:0] trig_src;
		logic [1:0] dpos;
		logic first_trig;
		logic ext_clk_pol;
		logic [4:0] intvl;
		logic [1:0] fmt;
	} la_ctrl_s;
	typedef struct packed {
		logic ext_trig;
		logic prb_qual;
		logic ext_clk;
		logic [N_CH-1:0] probe;
	} la_pins_s;
	typedef struct packed {
		logic [15:0] rsvd;
		logic wr_match;
		logic too_fast;
		logic trgd;
		logic full;
		logic [1:0] state;
		logic [9:0] wptr;
	} la_stat_s;
	// Interval in cycles: mantissa 1,2,5 times a power of ten
	function automatic logic [19:0] intvl_cyc(input logic [4:0] idx);
		logic [19:0] v;
		v = (idx % 3 == 0) ? 20'h1 : (idx % 3 == 1) ? 20'h2 : 20'h5;
		v = 20'(v * BASE_CYC);
		for (int i = 0; i < idx / 3; i++) begin
			v = 20'(v * 10);
		end
		return v;
	endfunction
endpackage

// File: verif/la_acq_assertions.sv
`timescale 1ns/1ps
module la_acq_assertions (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// Watched outputs
	input wire logic [1:0] o_fmt,
	input wire logic o_disp_store,
	input wire logic o_trig_int_n,
	input wire logic o_mreset,
	input wire logic o_triggered,
	input wire logic o_store_clk
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	// ==========
	// Cycle phases
	chk_phase_excl: assert property (!(o_disp_store && o_mreset))
		else $error("store and reset high together");
	chk_reset_short: assert property ($rose(o_mreset) |=> !o_mreset && o_disp_store)
		else $error("reset phase not followed by store");
	chk_store_entry: assert property ($rose(o_disp_store) |-> $past(o_mreset))
		else $error("store entered without reset");
	chk_disp_trig: assert property ($fell(o_disp_store) && !o_mreset |-> o_triggered)
		else $error("display without trigger");
	chk_fmt_code: assert property (o_fmt != 2'h1)
		else $error("illegal format code");
	// ==========
	// Trigger flag and markers
	chk_trig_hold: assert property ($fell(o_triggered) |-> o_mreset || $past(o_mreset))
		else $error("trigger flag dropped outside reset");
	chk_trig_clear: assert property ($rose(o_mreset) |-> ##[0:1] !o_triggered)
		else $error("trigger flag kept through reset");
	chk_intens_disp: assert property (!o_trig_int_n |-> !o_disp_store && !o_mreset)
		else $error("intensify outside display");
	// Pulse trails the decision by two cycles, so look back that far
	chk_store_gate: assert property (o_store_clk |-> $past(o_disp_store, 2))
		else $error("store clock outside store");
	cover property ($rose(o_triggered));
	cover property ($fell(o_trig_int_n));
	cover property ($rose(o_mreset));
	cover property (o_store_clk);
endmodule
bind la_acq la_acq_assertions u_chk (
	.i_clk_sys(i_clk_sys),
	.i_nrst(i_nrst),
	.o_fmt(o_fmt),
	.o_disp_store(o_disp_store),
	.o_trig_int_n(o_trig_int_n),
	.o_mreset(o_mreset),
	.o_triggered(o_triggered),
	.o_store_clk(o_store_clk)
);

// File: verif/la_cut_model.sv
`timescale 1ns/1ps
module la_cut_model (
	// Bench controls
	input wire logic i_run,
	input wire logic [15:0] i_word,
	input wire logic i_qual,
	input wire logic i_trig,
	// Probe side
	output la_pkg::la_pins_s o_pins
);
	logic clk_q;
	// ==========
	// Sample clock, parked low outside bursts, phase offset from the system clock
	initial begin
		clk_q = 1'h0;
		#3;
		forever begin
			#80;
			clk_q = i_run ? ~clk_q : 1'h0;
		end
	end
	assign o_pins = {i_trig, i_qual, clk_q, i_word};
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk, nrst, we, re, run, tg, pq, ds, tin, mr, trg, wm, sc, tfo;
	logic [5:0] addr;
	logic [31:0] wdata, r, rdata;
	logic [15:0] word;
	logic [1:0] fmt;
	logic [2:0] aux;
	la_pkg::la_pins_s pins;
	la_pkg::la_ctrl_s c;
	int n_mismatch, n_tests, n, k;
	logic [1:0] fx [3] = '{2'h3, 2'h2, 2'h0};
	logic [7:0] tft [6] = '{8'h41, 8'h42, 8'h83, 8'h84, 8'h00, 8'ha4};
	int pe [3] = '{247, 121, 0};
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	la_acq #(.DISP_UNIT_CYC(10), .INTVL_MAX_CYC(64)) u_dut (.i_clk_sys(clk), .i_nrst(nrst),
		.i_addr(addr), .i_wdata(wdata), .i_we(we), .i_re(re), .o_rdata(rdata),
		.i_probe(pins.probe), .i_ext_clk(pins.ext_clk), .i_prb_qual(pins.prb_qual),
		.i_ext_trig(pins.ext_trig), .o_fmt(fmt), .o_disp_store(ds), .o_trig_int_n(tin),
		.o_mreset(mr), .o_aux(aux), .o_triggered(trg), .o_too_fast(tfo), .o_wr_match(wm),
		.o_store_clk(sc));
	la_cut_model u_cut (.i_run(run), .i_word(word), .i_qual(pq), .i_trig(tg), .o_pins(pins));
	// ==========
	// Tasks
	task report_and_stop;
		if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task ck(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'h1;
		@(posedge clk);
		we <= 1'h0;
	endtask
	task rd(input logic [5:0] a);
		@(posedge clk);
		addr <= a;
		re <= 1'h1;
		@(posedge clk);
		re <= 1'h0;
		#1 r = rdata;
	endtask
	// Waits: 0 triggered, 1 display, 2 store, 3 match
	task wt(input int m, output int cnt);
		cnt = 0;
		while (!(m == 0 ? trg === 1'h1 : m == 1 ? (ds === 1'h0 && mr === 1'h0) :
			m == 2 ? ds === 1'h1 : wm === 1'h1)) begin
			@(posedge clk);
			#1;
			cnt++;
			if (cnt > 3000) begin
				n_mismatch++;
				report_and_stop();
			end
		end
	endtask
	task cnt_store(input int m, output int cnt);
		cnt = 0;
		repeat (m) begin
			@(posedge clk);
			#1;
			if (sc === 1'h1) cnt++;
		end
	endtask
	task restart;
		c.man_rst = 1'h1;
		wr(la_pkg::OFS_CTRL, c);
		c.man_rst = 1'h0;
		repeat (4) @(posedge clk);
		#1;
		wt(2, n);
	endtask
	task fire;
		c.man_trig = 1'h1;
		wr(la_pkg::OFS_CTRL, c);
		c.man_trig = 1'h0;
	endtask
	task settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// ==========
	// Sequence
	initial begin
		nrst = 1'h0;
		we = 1'h0;
		re = 1'h0;
		addr = 6'h00;
		wdata = 32'h0;
		run = 1'h0;
		tg = 1'h0;
		pq = 1'h1;
		word = 16'h0;
		c = '0;
		n_mismatch = 0;
		n_tests = 0;
		repeat (8) @(posedge clk);
		nrst <= 1'h1;
		repeat (4) @(posedge clk);
		rd(la_pkg::OFS_ROUTE);
		ck(r, 32'h88);
		rd(la_pkg::OFS_DISP);
		ck(r, 32'h64);
		rd(6'h3c);
		ck(r, 32'h0);
		for (int f = 0; f < 3; f++) begin
			c.fmt = 2'(f);
			wr(la_pkg::OFS_CTRL, c);
			settle();
			ck(fmt, fx[f]);
			ck(aux, {1'h1, fx[f][0], fx[f][1]});
		end
		wr(la_pkg::OFS_ROUTE, 32'h0d4);
		settle();
		ck(aux, 3'h6);
		foreach (tft[i]) begin
			c.fmt = tft[i][7:6];
			c.intvl = tft[i][5:1];
			wr(la_pkg::OFS_CTRL, c);
			rd(la_pkg::OFS_STAT);
			ck(r[14], tft[i][0]);
			// Lamp blinks 25 units on, 25 off: half of any 500-cycle window
			k = 0;
			repeat (500) begin
				@(posedge clk);
				#1;
				if (tfo === 1'h1) k++;
			end
			ck(k, tft[i][0] ? 250 : 0);
		end
		// Positions: fill after the trigger shrinks from post to pre
		wr(la_pkg::OFS_DISP, 32'h1e);
		c.fmt = 2'h2;
		c.intvl = 5'h0;
		c.first_trig = 1'h1;
		for (int p = 0; p < 3; p++) begin
			c.dpos = 2'(p);
			restart();
			fire();
			wt(0, n);
			ck(n < 6, 1'h1);
			wt(1, n);
			ck(n >= pe[p] && n <= pe[p] + 14, 1'h1);
			k = 0;
			n = 0;
			while (ds === 1'h0 && n < 1000) begin
				@(posedge clk);
				#1;
				n++;
				if (tin === 1'h0) k++;
			end
			ck(k != 0, 1'h1);
			// Unit prescaler runs free, so the hold may end up to one unit early
			ck(n >= 292 && n <= 303, 1'h1);
			if (n >= 1000) report_and_stop();
			ck(trg, 1'h0);
		end
		wr(la_pkg::OFS_DISP, 32'h400);
		restart();
		fire();
		wt(1, n);
		repeat (500) @(posedge clk);
		#1;
		ck({ds, mr}, 2'h0);
		restart();
		ck(n, 0);
		c.first_trig = 1'h0;
		c.dpos = 2'h0;
		restart();
		fire();
		repeat (10) @(posedge clk);
		#1;
		ck(trg, 1'h0);
		repeat (300) @(posedge clk);
		fire();
		wt(0, n);
		ck(n < 6, 1'h1);
		// Ext trigger: idle on the active level, so the wrong edge comes first
		c.first_trig = 1'h1;
		c.trig_src = 2'h1;
		for (int e = 0; e < 2; e++) begin
			c.ext_trig_pol = 1'(e);
			@(posedge clk);
			tg <= ~1'(e);
			restart();
			@(posedge clk);
			tg <= 1'(e);
			repeat (20) @(posedge clk);
			#1;
			ck(trg, 1'h0);
			@(posedge clk);
			tg <= ~1'(e);
			wt(0, n);
			ck(n < 12, 1'h1);
		end
		c.trig_src = 2'h0;
		restart();
		@(posedge clk);
		word <= 16'h1;
		wt(0, n);
		ck(n < 12, 1'h1);
		wr(la_pkg::OFS_CARE, 32'h3fff7);
		wr(la_pkg::OFS_LVL, 32'h2a5a5);
		wr(la_pkg::OFS_FILT, 32'h14);
		c.trig_src = 2'h2;
		c.wr_async = 1'h1;
		@(posedge clk);
		word <= 16'h0;
		tg <= 1'h0;
		restart();
		@(posedge clk);
		word <= 16'ha5ad;
		repeat (10) @(posedge clk);
		word <= 16'h0;
		k = 0;
		repeat (30) begin
			@(posedge clk);
			#1;
			if (wm === 1'h1) k++;
		end
		ck({k[7:0], trg}, 9'h0);
		@(posedge clk);
		word <= 16'ha5ad;
		wt(3, n);
		ck(n >= 20 && n <= 30, 1'h1);
		wt(0, n);
		ck(n < 4, 1'h1);
		@(posedge clk);
		word <= 16'h0;
		repeat (5) @(posedge clk);
		c.wr_async = 1'h0;
		restart();
		@(posedge clk);
		word <= 16'ha5ad;
		k = 0;
		repeat (40) begin
			@(posedge clk);
			#1;
			if (wm === 1'h1) k++;
		end
		ck(k, 0);
		@(posedge clk);
		run <= 1'h1;
		wt(3, n);
		ck(n < 40, 1'h1);
		@(posedge clk);
		run <= 1'h0;
		c.trig_src = 2'h0;
		c.qual_en = 1'h1;
		c.qual_lvl = 1'h1;
		restart();
		@(posedge clk);
		pq <= 1'h0;
		repeat (6) @(posedge clk);
		cnt_store(50, k);
		ck(k, 0);
		@(posedge clk);
		pq <= 1'h1;
		repeat (6) @(posedge clk);
		cnt_store(50, k);
		ck(k, 50);
		wr(la_pkg::OFS_MIDX, 32'h0);
		rd(la_pkg::OFS_MDAT);
		ck(r, 32'ha5ad);
		c.qual_en = 1'h0;
		c.intvl = 5'h12;
		restart();
		cnt_store(50, k);
		ck(k, 0);
		@(posedge clk);
		run <= 1'h1;
		cnt_store(160, k);
		ck(k >= 9 && k <= 11, 1'h1);
		report_and_stop();
	end
endmodule
